/* File: acp_io_port.sv */
// Functional notes
// - each port has 8-bit read/write pull-up enable register, one bit per pin
// - modes 2,3,6,7: pull-up on only when direction 0 and pull-up bit 1
// - modes 1,4,5: all pull-ups of the port off
// - pull-up register cleared by power-on reset and hardware standby only
// - modes 1,4,5: all pins drive address outputs, direction ignored
// - modes 2,6: direction 1 gives address output, 0 gives input
// - modes 3,7: direction 1 drives output latch, 0 gives input
// - direction register 8-bit write-only; reads return undefined value
// - direction cleared by power-on reset and hardware standby only
// - software standby: address pins hold or float per hold control bit
// - output latch 8-bit read/write, cleared by power-on and hw standby
// - pin-state register read-only; writes ignored, software writes latch
// - pin-state read gives latch where direction 1, pin level where 0
// - pin-state follows pins after reset, frozen in manual reset, sw standby
// - pull-up and direction independent per bit
// - registers decoded at fixed low 16-bit addresses
// - flash variant lacks modes 1-3; romless variant lacks modes 2,3,6,7
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module acp_io_port
  import acp_pkg::*;
#(
  parameter bit P_FLASH   = 1'b0,
  parameter bit P_ROMLESS = 1'b0
)(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_hw_standby,
  input  wire logic        i_manual_rst,
  input  wire logic        i_sw_standby,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic [7:0]  i_addr_bus,
  input  wire logic [7:0]  i_first_port_direction,
  input  wire logic [7:0]  i_pin_in,
  output logic      [7:0]  o_pin_out,
  output logic      [7:0]  o_pin_oe,
  output logic      [7:0]  o_second_pullup,
  output logic      [7:0]  o_first_pullup,
  output logic      [2:0]  o_mode,
  output logic             o_mode_valid
);
  logic       rst_s1_q;
  logic       rst_n;
  logic [9:0] sy1_q;
  logic [9:0] sy2_q;
  logic [9:0] sy3_q;
  logic [9:0] flt_q;
  logic [2:0] mode_q;
  logic       cap_q;
  logic [7:0] dir_q;
  logic [7:0] latch_q;
  logic [7:0] pu_sec_q;
  logic [7:0] pu_first_q;
  logic       hold_q;
  logic [7:0] pins_q;
  logic [7:0] addr_q;
  logic [7:0] out_d;
  logic [7:0] oe_d;
  logic [7:0] pull_sec_d;
  logic [7:0] pull_first_d;
  logic       mvalid_q;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // pins and hw standby/manual reset lines: three flops, change taken on 2=3
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_q <= 10'h000;
      sy2_q <= 10'h000;
      sy3_q <= 10'h000;
      flt_q <= 10'h000;
    end
    else
    begin
      sy1_q <= {i_manual_rst, i_hw_standby, i_pin_in};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      flt_q <= (sy2_q & sy3_q) | (flt_q & (sy2_q | sy3_q));
    end
  end

  wire       man_s  = flt_q[9];
  wire       hw_s   = flt_q[8];
  wire [7:0] pin_s  = flt_q[7:0];

  // mode caught once after reset release, never again
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= RST_MODE;
      cap_q  <= 1'b0;
    end
    else if (!cap_q)
    begin
      mode_q <= i_mode;
      cap_q  <= 1'b1;
    end
  end

  wire m_abus  = (mode_q == MODE_1) || (mode_q == MODE_4)
              || (mode_q == MODE_5);
  wire m_asel  = (mode_q == MODE_2) || (mode_q == MODE_6);
  wire m_gpio  = (mode_q == MODE_3) || (mode_q == MODE_7);
  wire m_1to3  = (mode_q == MODE_1) || (mode_q == MODE_2)
              || (mode_q == MODE_3);
  wire m_onchp = m_asel || m_gpio;
  // unoffered modes leave every pin an input with no pull-up
  wire m_ok    = cap_q && (m_abus || m_onchp)
              && !(P_FLASH && m_1to3) && !(P_ROMLESS && m_onchp);
  wire abus_all = m_ok && m_abus;
  wire abus_sel = m_ok && m_asel;
  wire gpio     = m_ok && m_gpio;
  wire pu_mode  = abus_sel || gpio;

  // register decode
  wire acc_ok    = cap_q && !man_s && !hw_s;
  wire we        = i_wr && acc_ok;
  wire hit_pu1   = (i_addr == OFS_FIRST_PULLUP);
  wire hit_dir   = (i_addr == OFS_SEC_DIR);
  wire hit_pins  = (i_addr == OFS_SEC_PINS);
  wire hit_latch = (i_addr == OFS_SEC_LATCH);
  wire hit_pu2   = (i_addr == OFS_SEC_PULLUP);
  wire hit_stby  = (i_addr == OFS_STBY_CTRL);
  wire hit_any   = hit_pu1 || hit_dir || hit_pins || hit_latch
                || hit_pu2 || hit_stby;

  // only power-on reset and hw standby clear; manual reset keeps all
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir_q      <= RST_DIR;
      latch_q    <= RST_LATCH;
      pu_sec_q   <= RST_PULLUP;
      pu_first_q <= RST_PULLUP;
      hold_q     <= RST_HOLD;
    end
    else if (hw_s)
    begin
      dir_q      <= RST_DIR;
      latch_q    <= RST_LATCH;
      pu_sec_q   <= RST_PULLUP;
      pu_first_q <= RST_PULLUP;
      hold_q     <= RST_HOLD;
    end
    else if (we)
    begin
      if (hit_dir)
        dir_q <= i_wdata;
      if (hit_latch)
        latch_q <= i_wdata;
      if (hit_pu2)
        pu_sec_q <= i_wdata;
      if (hit_pu1)
        pu_first_q <= i_wdata;
      if (hit_stby)
        hold_q <= i_wdata[HOLD_BIT];
    end
  end

  // pin sample frozen while manual reset or software standby
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      pins_q <= ALL_OFF;
    else if (!man_s && !i_sw_standby)
      pins_q <= pin_s;
  end

  // last address kept for standby hold
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_q <= ALL_OFF;
    else if (!i_sw_standby)
      addr_q <= i_addr_bus;
  end

  wire [7:0] pin_state = (dir_q & latch_q) | (~dir_q & pins_q);
  wire [7:0] rd_mux =
      hit_pu1   ? pu_first_q   :
      hit_dir   ? DIR_RD_VALUE :
      hit_pins  ? pin_state    :
      hit_latch ? latch_q      :
      hit_pu2   ? pu_sec_q     :
      hit_stby  ? {7'h00, hold_q} : UNMAPPED_RD;
  // writes to the pin-state address fall through decode

  wire [7:0] a_src  = i_sw_standby ? addr_q : i_addr_bus;
  wire [7:0] a_en   = i_sw_standby ? {8{hold_q}} : ALL_ON;
  wire [7:0] a_pins = abus_all ? ALL_ON : (abus_sel ? dir_q : ALL_OFF);

  always_comb
  begin
    out_d = ALL_OFF;
    oe_d  = ALL_OFF;
    if (hw_s)
    begin
      out_d = ALL_OFF;
      oe_d  = ALL_OFF;
    end
    else if (abus_all || abus_sel)
    begin
      out_d = a_src;
      oe_d  = a_pins & a_en;
    end
    else if (gpio)
    begin
      out_d = latch_q;
      oe_d  = dir_q;
    end
  end

  // pull-up only on inputs in modes that allow it
  assign pull_sec_d   = pu_mode ? (~dir_q & pu_sec_q) : ALL_OFF;
  assign pull_first_d = pu_mode ? (~i_first_port_direction & pu_first_q)
                                : ALL_OFF;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_pin_out       <= ALL_OFF;
      o_pin_oe        <= ALL_OFF;
      o_second_pullup <= ALL_OFF;
      o_first_pullup  <= ALL_OFF;
      o_rdata         <= UNMAPPED_RD;
    end
    else
    begin
      o_pin_out       <= out_d;
      o_pin_oe        <= oe_d;
      o_second_pullup <= pull_sec_d;
      o_first_pullup  <= pull_first_d;
      // data stands only in the cycle after the read strobe
      o_rdata         <= (i_rd && acc_ok) ? rd_mux : UNMAPPED_RD;
    end
  end

  // offered-mode flag kept in a flop like the other data outputs
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      mvalid_q <= 1'b0;
    else
      mvalid_q <= m_ok;
  end

  assign o_mode       = mode_q;
  assign o_mode_valid = mvalid_q;

  a_pullup_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
    pu_mode |=> o_second_pullup == (~$past(dir_q) & $past(pu_sec_q)))
    else $error("pull-up not gated by direction and enable");
  a_pullup_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    abus_all |=> (o_second_pullup == ALL_OFF) && (o_first_pullup == ALL_OFF))
    else $error("pull-up on in an address-only mode");
  a_abus_drive: assert property (@(posedge i_clk) disable iff (!rst_n)
    abus_all && !i_sw_standby && !hw_s |=> o_pin_oe == ALL_ON
      && o_pin_out == $past(i_addr_bus))
    else $error("address pins not all driven");
  a_asel_dir: assert property (@(posedge i_clk) disable iff (!rst_n)
    abus_sel && !i_sw_standby && !hw_s |=> o_pin_oe == $past(dir_q))
    else $error("address select ignores direction");
  a_gpio_dir: assert property (@(posedge i_clk) disable iff (!rst_n)
    gpio && !hw_s |=> o_pin_oe == $past(dir_q)
      && o_pin_out == $past(latch_q))
    else $error("gpio output not from latch");
  a_dir_read: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && acc_ok && hit_dir |=> o_rdata == DIR_RD_VALUE)
    else $error("direction read returned stored bits");
  a_hw_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
    hw_s |=> dir_q == RST_DIR && latch_q == RST_LATCH
      && pu_sec_q == RST_PULLUP)
    else $error("hardware standby did not clear");
  a_manual_keep: assert property (@(posedge i_clk) disable iff (!rst_n)
    man_s && !hw_s |=> $stable(dir_q) && $stable(pu_sec_q)
      && $stable(latch_q) && $stable(pins_q))
    else $error("manual reset disturbed registers");
  a_stby_float: assert property (@(posedge i_clk) disable iff (!rst_n)
    abus_all && i_sw_standby && !hold_q && !hw_s |=> o_pin_oe == ALL_OFF)
    else $error("address pins not floated in standby");
  a_pins_ro: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && hit_pins && !hw_s |=> $stable(latch_q) && $stable(dir_q))
    else $error("write to pin-state changed a register");
  a_pin_read: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && acc_ok && hit_pins ##1 1 |-> o_rdata == $past(pin_state))
    else $error("pin-state read mismatch");

  // register writes land the cycle after the strobe
  a_latch_wr: assert property (@(posedge i_clk) disable iff (!rst_n)
    we && hit_latch |=> latch_q == $past(i_wdata))
    else $error("output latch write lost");
  a_dir_wr: assert property (@(posedge i_clk) disable iff (!rst_n)
    we && hit_dir |=> dir_q == $past(i_wdata))
    else $error("direction write lost");
  a_pu_wr: assert property (@(posedge i_clk) disable iff (!rst_n)
    we && hit_pu2 |=> pu_sec_q == $past(i_wdata))
    else $error("pull-up enable write lost");
  a_first_gate: assert property (@(posedge i_clk) disable iff (!rst_n)
    pu_mode |=> o_first_pullup
      == (~$past(i_first_port_direction) & $past(pu_first_q)))
    else $error("first port pull-up not gated");

  // mode stays put once taken; variants lose their removed modes
  a_mode_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    cap_q |=> cap_q && $stable(mode_q))
    else $error("captured mode changed");
  a_variant: assert property (@(posedge i_clk) disable iff (!rst_n)
    (P_ROMLESS && m_onchp) || (P_FLASH && m_1to3) |=> !o_mode_valid)
    else $error("variant offers a removed mode");
  a_offer_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    !m_ok |=> o_pin_oe == ALL_OFF && o_second_pullup == ALL_OFF
      && o_first_pullup == ALL_OFF)
    else $error("unoffered mode drives a pin");

  // read data only in the cycle after an accepted strobe
  a_rd_idle: assert property (@(posedge i_clk) disable iff (!rst_n)
    !(i_rd && acc_ok) |=> o_rdata == UNMAPPED_RD)
    else $error("read data outside its cycle");
  a_unmapped: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && acc_ok && !hit_any |=> o_rdata == UNMAPPED_RD)
    else $error("unmapped address answered");

  // standby and reset behaviour
  a_hw_rest: assert property (@(posedge i_clk) disable iff (!rst_n)
    hw_s |=> pu_first_q == RST_PULLUP && hold_q == RST_HOLD
      && o_pin_oe == ALL_OFF)
    else $error("hardware standby left state behind");
  a_man_rest: assert property (@(posedge i_clk) disable iff (!rst_n)
    man_s && !hw_s |=> $stable(pu_first_q) && $stable(hold_q))
    else $error("manual reset changed a control bit");
  a_hw_track: assert property (@(posedge i_clk) disable iff (!rst_n)
    hw_s && !man_s && !i_sw_standby |=> pins_q == $past(pin_s))
    else $error("pin-state not following pins");
  a_sw_freeze: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_sw_standby |=> $stable(pins_q))
    else $error("pin-state moved in software standby");
  a_stby_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
    abus_all && i_sw_standby && hold_q && !hw_s |=> o_pin_oe == ALL_ON
      && o_pin_out == $past(addr_q))
    else $error("address not held in standby");
  a_asel_out: assert property (@(posedge i_clk) disable iff (!rst_n)
    abus_sel && !i_sw_standby && !hw_s |=> o_pin_out == $past(i_addr_bus))
    else $error("address select drives wrong value");

  c_gpio_out: cover property (@(posedge i_clk) disable iff (!rst_n)
    gpio && we && hit_latch ##1 o_pin_oe != ALL_OFF);
  c_stby_hold: cover property (@(posedge i_clk) disable iff (!rst_n)
    abus_all && i_sw_standby && hold_q);
  c_pull_on: cover property (@(posedge i_clk) disable iff (!rst_n)
    o_second_pullup != ALL_OFF);
  c_asel_in: cover property (@(posedge i_clk) disable iff (!rst_n)
    abus_sel && (dir_q != ALL_ON) && (dir_q != ALL_OFF));
  c_hw_clear: cover property (@(posedge i_clk) disable iff (!rst_n)
    hw_s ##1 !hw_s);
endmodule

/* File: acp_pkg.sv */
package acp_pkg;
  localparam int         ACP_W            = 8;
  localparam int         ACP_AW           = 16;
  // register offsets, low 16 bits of the bus address
  localparam logic [15:0] OFS_FIRST_PULLUP = 16'hFF71;
  localparam logic [15:0] OFS_SEC_DIR      = 16'hFEBB;
  localparam logic [15:0] OFS_SEC_PINS     = 16'hFF5B;
  localparam logic [15:0] OFS_SEC_LATCH    = 16'hFF6B;
  localparam logic [15:0] OFS_SEC_PULLUP   = 16'hFF72;
  localparam logic [15:0] OFS_STBY_CTRL    = 16'hFF74;
  // reset values
  localparam logic [7:0]  RST_DIR          = 8'h00;
  localparam logic [7:0]  RST_LATCH        = 8'h00;
  localparam logic [7:0]  RST_PULLUP       = 8'h00;
  localparam logic        RST_HOLD         = 1'b0;
  localparam logic [2:0]  RST_MODE         = 3'h0;
  // answer for the write-only direction register and holes
  localparam logic [7:0]  DIR_RD_VALUE     = 8'hFF;
  localparam logic [7:0]  UNMAPPED_RD      = 8'h00;
  localparam int          HOLD_BIT         = 0;
  localparam logic [7:0]  ALL_ON           = 8'hFF;
  localparam logic [7:0]  ALL_OFF          = 8'h00;
  // operating modes
  localparam logic [2:0]  MODE_1 = 3'h1;
  localparam logic [2:0]  MODE_2 = 3'h2;
  localparam logic [2:0]  MODE_3 = 3'h3;
  localparam logic [2:0]  MODE_4 = 3'h4;
  localparam logic [2:0]  MODE_5 = 3'h5;
  localparam logic [2:0]  MODE_6 = 3'h6;
  localparam logic [2:0]  MODE_7 = 3'h7;
endpackage

/* File: acp_pin_partner.sv */
`timescale 1ns/1ps
// far side of the second port: board wiring and one outside driver
module acp_pin_partner (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_pin_out,
  input  wire logic [7:0] i_pin_oe,
  input  wire logic [7:0] i_pullup,
  input  wire logic [7:0] i_ext_val,
  input  wire logic [7:0] i_ext_oe,
  output logic      [7:0] o_pin_in
);
  logic [7:0] float_q = 8'h55;
  // an undriven pin without pull-up toggles every clock, so the port's 2=3 filter holds its last value
  always @(posedge i_clk)
    float_q <= ~float_q;
  always_comb
    for (int b = 0; b < 8; b++)
      o_pin_in[b] = i_pin_oe[b] ? i_pin_out[b] :
                    i_ext_oe[b] ? i_ext_val[b] :
                    i_pullup[b] ? 1'b1 : float_q[b];
endmodule

/* File: acp_io_port_tb_top.sv */
`timescale 1ns/1ps
module acp_io_port_tb_top;
  import acp_pkg::*;
  logic clk = 0, nrst = 0, hw = 0, man = 0, sw = 0, wr = 0, rd = 0;
  logic [2:0] mode = 3'h3;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, abus = 8'h00, fdir = 8'h0F;
  logic [7:0] ext_val = 8'h00, ext_oe = 8'h00;
  logic [7:0] rdata, pout, poe, pu2, pu1, pin, d, eo, poe_r;
  logic [2:0] omode;
  logic mvalid, mvalid_r;
  int mismatches = 0, compares = 0;
  acp_io_port u_acp_io_port (.i_clk(clk), .i_nrst(nrst), .i_mode(mode),
    .i_hw_standby(hw), .i_manual_rst(man), .i_sw_standby(sw),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_addr_bus(abus), .i_first_port_direction(fdir), .i_pin_in(pin),
    .o_pin_out(pout), .o_pin_oe(poe), .o_second_pullup(pu2),
    .o_first_pullup(pu1), .o_mode(omode), .o_mode_valid(mvalid));
  acp_pin_partner u_acp_pin_partner (.i_clk(clk), .i_pin_out(pout),
    .i_pin_oe(poe), .i_pullup(pu2), .i_ext_val(ext_val), .i_ext_oe(ext_oe),
    .o_pin_in(pin));
  // second copy built without on-chip program memory
  acp_io_port #(.P_ROMLESS(1'b1)) u_acp_io_port_romless (.i_clk(clk),
    .i_nrst(nrst), .i_mode(mode), .i_hw_standby(hw), .i_manual_rst(man),
    .i_sw_standby(sw), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(), .i_addr_bus(abus), .i_first_port_direction(fdir),
    .i_pin_in(pin), .o_pin_out(), .o_pin_oe(poe_r), .o_second_pullup(),
    .o_first_pullup(), .o_mode(), .o_mode_valid(mvalid_r));
  initial
    forever #12.5 clk = ~clk;
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic restart(input logic [2:0] m);
    @(posedge clk);
    nrst <= 1'b0;
    mode <= m;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    cyc(6);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end
  initial
  begin
    restart(MODE_3);
    rchk(OFS_SEC_LATCH, 8'h00);
    rchk(OFS_SEC_PULLUP, 8'h00);
    rchk(OFS_FIRST_PULLUP, 8'h00);
    rchk(OFS_SEC_DIR, DIR_RD_VALUE);
    rchk(16'hFF75, UNMAPPED_RD);
    chk(poe, 8'h00);
    $display("test reset values done");
    wreg(OFS_SEC_DIR, 8'h0F);
    wreg(OFS_SEC_LATCH, 8'h5A);
    wreg(OFS_SEC_PULLUP, 8'hF0);
    wreg(OFS_SEC_PINS, 8'hFF);
    ext_oe <= 8'hF0;
    ext_val <= 8'hA0;
    cyc(6);
    chk(poe, 8'h0F);
    chk(pout & 8'h0F, 8'h0A);
    chk(pu2, 8'hF0);
    rchk(OFS_SEC_PINS, 8'hAA);
    rchk(OFS_SEC_LATCH, 8'h5A);
    rchk(OFS_SEC_PULLUP, 8'hF0);
    $display("test general io done");
    @(posedge clk);
    man <= 1'b1;
    repeat (8) @(posedge clk);
    man <= 1'b0;
    cyc(6);
    rchk(OFS_SEC_LATCH, 8'h5A);
    rchk(OFS_SEC_PULLUP, 8'hF0);
    chk(poe, 8'h0F);
    @(posedge clk);
    ext_oe <= 8'hFF;
    ext_val <= 8'hA5;
    hw <= 1'b1;
    cyc(8);
    chk(poe, 8'h00);
    @(posedge clk);
    hw <= 1'b0;
    cyc(8);
    rchk(OFS_SEC_LATCH, 8'h00);
    rchk(OFS_SEC_PULLUP, 8'h00);
    rchk(OFS_SEC_PINS, 8'hA5);
    $display("test resets and standby done");
    @(posedge clk);
    ext_oe <= 8'h00;
    for (int m = 0; m < 8; m++)
    begin
      restart(m[2:0]);
      chk({5'h00, omode}, 8'(m));
      wreg(OFS_SEC_DIR, 8'h0F);
      wreg(OFS_SEC_LATCH, 8'h5A);
      wreg(OFS_SEC_PULLUP, 8'hFF);
      wreg(OFS_FIRST_PULLUP, 8'hFF);
      abus <= 8'h3C;
      cyc(5);
      eo = (m inside {1, 4, 5}) ? 8'hFF : (m == 0) ? 8'h00 : 8'h0F;
      d = (m inside {3, 7}) ? 8'h0A : 8'h3C & eo;
      chk(poe, eo);
      chk(pout & eo, d);
      eo = (m inside {2, 3, 6, 7}) ? 8'hF0 : 8'h00;
      chk(pu2, eo);
      chk(pu1, eo);
      chk({7'h00, mvalid}, (m == 0) ? 8'h00 : 8'h01);
      chk({7'h00, mvalid_r}, (m inside {1, 4, 5}) ? 8'h01 : 8'h00);
      chk(poe_r, (m inside {1, 4, 5}) ? 8'hFF : 8'h00);
    end
    $display("test mode table done");
    restart(MODE_1);
    wreg(OFS_STBY_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    sw <= 1'b1;
    repeat (2) @(posedge clk);
    abus <= 8'hC3;
    cyc(3);
    chk(poe, 8'hFF);
    chk(pout, 8'h3C);
    @(posedge clk);
    sw <= 1'b0;
    wreg(OFS_STBY_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    sw <= 1'b1;
    cyc(4);
    chk(poe, 8'h00);
    @(posedge clk);
    sw <= 1'b0;
    $display("test software standby done");
    close_out();
  end
endmodule
